/* rtl/reset_strap_pkg.sv */
package reset_strap_pkg;

    // Soft reset drive length on the reset pin, in clocks
    localparam int unsigned SOFT_PULSE_CYCLES = 124;
    localparam int unsigned SOFT_CNT_W = 7;
    // Least total reset hold kept by the outside source, in clocks
    localparam int unsigned TOTAL_MIN_CYCLES = 10;
    // Clock multipliers selected by the straps
    localparam logic [8:0] MULT_BYPASS = 9'h001;
    localparam logic [8:0] MULT_LOW = 9'h004;
    localparam logic [8:0] MULT_HIGH = 9'h191;
    // Peripheral reset vector positions
    localparam int unsigned PERIPH_COMMS = 0;
    localparam int unsigned PERIPH_DMA = 1;
    localparam int unsigned PERIPH_TIMER1 = 2;
    localparam int unsigned PERIPH_TIMER2 = 3;
    localparam int unsigned PERIPH_N = 4;
    // Values after reset
    localparam logic [1:0] DRIVE_RESET = 2'h3;

    typedef enum logic [1:0] {
        DRIVE_OFF = 2'h0,
        DRIVE_THIRD = 2'h1,
        DRIVE_TWO_THIRDS = 2'h2,
        DRIVE_FULL = 2'h3
    } drive_t;

    // Straps captured during total reset
    typedef struct packed {
        logic bus_16;
        logic core_off;
        logic pll_on;
        logic clk_mode;
    } strap_t;

    // Pin-state controls for the pad ring
    typedef struct packed {
        logic bus_float;
        logic strobes_high;
        logic internal_access_low;
        logic gpio_inputs;
        logic watchdog_open_drain;
        logic serial_one_safe;
    } pin_ctrl_t;

endpackage : reset_strap_pkg

/* rtl/reset_and_mode_strap_control.sv */
`timescale 1ns/1ps
// What this block does
// - Reset plus halt together start total reset
// - Reset instruction drives reset pin 124 clocks
// - Soft reset spares core, resets comms, integration
// - Total reset floats bus, strobes high
// - Grant follows request during total reset
// - GPIO inputs, watchdog open drain in reset
// - Serial one inputs, RTS and TXD high
// - Clock output runs during total reset
// - Reset leaves system RAM contents alone
// - Peripheral reset bits reset that peripheral
// - Halt stops master after current cycle
// - Bus width strap taken only in reset
// - Sixteen-bit mode allows word lanes
// - Eight-bit mode limits accesses to bytes
// - Core disable strap taken in reset
// - Clock mode sampled in reset with PLL strap on, else port
// - PLL strap off selects bypass; with PLL on, clock mode picks 4 or 401
// - Software sets clock output drive strength
// - Clock output is the system clock
module reset_and_mode_strap_control
    import reset_strap_pkg::*;
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic reset_pin_n_in, // Reset pin level
    input wire logic halt_pin_n_in, // Halt pin level
    input wire logic bus_width_select, // Bus width strap pin
    input wire logic core_disable_strap, // Core disable strap pin
    input wire logic clock_mode_strap, // Clock mode pin
    input wire logic pll_supply_strap, // PLL supply strap pin
    input wire logic request_input_n, // Bus request pin
    input wire logic reset_instr, // Core executed reset instruction
    input wire logic [reset_strap_pkg::PERIPH_N-1:0] periph_reset_bit, // Register reset bits
    input wire logic bus_cycle_done, // Current bus cycle ends
    input wire logic upper_byte_strobe_n, // Upper byte strobe
    input wire logic lower_byte_strobe_n, // Lower byte strobe
    input wire reset_strap_pkg::drive_t clk_drive_cfg, // Clock output drive setting
    output logic reset_pin_out, // Reset pin output level
    output logic reset_pin_oe_n, // Reset pin enable, low drives
    output logic grant_output_n, // Bus grant pin
    output logic total_reset, // Total reset in progress
    output logic core_reset, // Core reset
    output logic comms_reset, // Communications processor reset
    output logic integ_reset, // Integration block reset
    output logic [reset_strap_pkg::PERIPH_N-1:0] periph_reset, // Per-peripheral reset
    output reset_strap_pkg::pin_ctrl_t pin_ctrl, // Pad states
    output reset_strap_pkg::strap_t straps, // Latched straps
    output logic [8:0] pll_mult, // PLL multiply factor
    output logic port_a_line_twelve, // Clock mode pin as port line
    output logic master_stopped, // Internal master halted
    output logic upper_lane_en, // Upper byte lane in use
    output logic lower_lane_en, // Lower byte lane in use
    output logic comms_ram_word, // Comms side of RAM stays word
    output logic clkout_enable, // Clock output enable
    output reset_strap_pkg::drive_t clkout_drive // Clock output drive
);
    import reset_strap_pkg::*;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_TOTAL = 3'h2,
        ST_SOFT = 3'h4
    } state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    wire [6:0] pins_raw = {reset_pin_n_in, halt_pin_n_in, bus_width_select,
        core_disable_strap, clock_mode_strap, pll_supply_strap, request_input_n};

    // Two flops per pin; only sync2 is read by logic
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_reg <= 7'h7f;
            sync2_reg <= 7'h7f;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    wire reset_s_n = sync2_reg[6];
    wire halt_s_n = sync2_reg[5];
    wire width_s = sync2_reg[4];
    wire core_off_s = sync2_reg[3];
    wire clkmode_s = sync2_reg[2];
    wire pll_s = sync2_reg[1];
    wire req_s_n = sync2_reg[0];

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    state_t state_reg, state_next;
    logic [SOFT_CNT_W-1:0] cnt_reg, cnt_next;
    logic reset_instr_reg;
    // Our own reset drive cannot alias a total reset: halt must join it
    wire total_req = !reset_s_n && !halt_s_n;
    wire soft_done = (cnt_reg == SOFT_CNT_W'(SOFT_PULSE_CYCLES - 1));

    // Next state: total reset wins over everything
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_RUN:
            begin
                cnt_next = '0;
                if (total_req)
                    state_next = ST_TOTAL;
                else if (reset_instr_reg)
                    state_next = ST_SOFT;
            end
            ST_TOTAL:
            begin
                if (!total_req)
                    state_next = ST_RUN;
            end
            ST_SOFT:
            begin
                cnt_next = cnt_reg + SOFT_CNT_W'(1);
                if (total_req)
                    state_next = ST_TOTAL;
                else if (soft_done)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    // State, counter and instruction capture
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= ST_RUN;
            cnt_reg <= '0;
            reset_instr_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            reset_instr_reg <= reset_instr;
        end
    end

    wire in_total = (state_next == ST_TOTAL);
    wire in_soft = (state_next == ST_SOFT);

    // ----------------------------------------------------------------
    // Straps and mode decode
    // ----------------------------------------------------------------
    strap_t strap_reg;
    // Straps only follow the pins while total reset holds
    always_ff @(posedge clk)
    begin
        if (srst)
            strap_reg <= '0;
        else if (state_reg == ST_TOTAL)
        begin
            strap_reg.bus_16 <= width_s;
            strap_reg.core_off <= core_off_s;
            strap_reg.pll_on <= pll_s;
            strap_reg.clk_mode <= pll_s & clkmode_s;
        end
    end

    wire [8:0] mult_sel = !strap_reg.pll_on ? MULT_BYPASS :
        (strap_reg.clk_mode ? MULT_HIGH : MULT_LOW);
    // Byte lanes: narrow bus moves one byte on the low lane
    wire any_strobe = !upper_byte_strobe_n || !lower_byte_strobe_n;
    wire upper_sel = strap_reg.bus_16 && !upper_byte_strobe_n;
    wire lower_sel = strap_reg.bus_16 ? !lower_byte_strobe_n : any_strobe;
    // Halt alone stops the bus master once its cycle ends
    wire halt_only = !halt_s_n && reset_s_n;
    wire stop_next = halt_only && (master_stopped || bus_cycle_done);

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Reset fan-out; no RAM clear strobe exists, RAM keeps its contents
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            total_reset <= 1'b0;
            core_reset <= 1'b0;
            comms_reset <= 1'b0;
            integ_reset <= 1'b0;
            periph_reset <= '0;
            reset_pin_out <= 1'b1;
            reset_pin_oe_n <= 1'b1;
        end
        else
        begin
            total_reset <= in_total;
            core_reset <= in_total;
            comms_reset <= in_total || in_soft;
            integ_reset <= in_total || in_soft;
            periph_reset <= {PERIPH_N{in_total}} | periph_reset_bit;
            reset_pin_out <= !in_soft;
            reset_pin_oe_n <= !in_soft;
        end
    end

    // Pad states, grant and clock output
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_ctrl <= '0;
            grant_output_n <= 1'b1;
            clkout_enable <= 1'b1;
            clkout_drive <= drive_t'(DRIVE_RESET);
        end
        else
        begin
            pin_ctrl <= {6{in_total}};
            grant_output_n <= in_total ? req_s_n : 1'b1;
            clkout_enable <= in_total || (clk_drive_cfg != DRIVE_OFF);
            clkout_drive <= in_total ? drive_t'(DRIVE_RESET) : clk_drive_cfg;
        end
    end

    // Straps, multiplier, port line, halt and lanes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            straps <= '0;
            pll_mult <= MULT_BYPASS;
            port_a_line_twelve <= 1'b0;
            master_stopped <= 1'b0;
            upper_lane_en <= 1'b0;
            lower_lane_en <= 1'b0;
            comms_ram_word <= 1'b1;
        end
        else
        begin
            straps <= strap_reg;
            pll_mult <= mult_sel;
            port_a_line_twelve <= (in_total && pll_s) ? 1'b0 : clkmode_s;
            master_stopped <= stop_next;
            upper_lane_en <= upper_sel;
            lower_lane_en <= lower_sel;
            comms_ram_word <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence seq_total_req;
        !reset_s_n && !halt_s_n && state_reg == ST_RUN;
    endsequence

    sequence seq_soft_start;
        state_reg == ST_RUN && reset_instr_reg && !total_req;
    endsequence

    chk_total_entry: assert property (@(posedge clk) disable iff (srst)
        seq_total_req |=> total_reset && core_reset && pin_ctrl.bus_float)
        else $error("total reset not entered");

    chk_soft_pulse_len: assert property (@(posedge clk) disable iff (srst)
        seq_soft_start ##1 (!total_req && state_reg == ST_SOFT) [*8]
        |-> !reset_pin_oe_n && !reset_pin_out)
        else $error("reset pin not driven");

    chk_soft_end: assert property (@(posedge clk) disable iff (srst)
        state_reg == ST_SOFT && soft_done && !total_req |=> reset_pin_oe_n)
        else $error("reset pin drive length wrong");

    chk_soft_core_kept: assert property (@(posedge clk) disable iff (srst)
        !reset_pin_oe_n |-> !core_reset && comms_reset && integ_reset)
        else $error("soft reset fan-out wrong");

    chk_grant_follow: assert property (@(posedge clk) disable iff (srst)
        total_reset |-> grant_output_n == $past(req_s_n))
        else $error("grant does not follow request");

    chk_clk_running: assert property (@(posedge clk) disable iff (srst)
        total_reset |-> clkout_enable)
        else $error("clock output stopped in reset");

    chk_periph_bit: assert property (@(posedge clk) disable iff (srst)
        periph_reset_bit[PERIPH_TIMER1] |=> periph_reset[PERIPH_TIMER1])
        else $error("peripheral reset missed");

    chk_halt_stop: assert property (@(posedge clk) disable iff (srst)
        halt_only && bus_cycle_done |=> master_stopped)
        else $error("master not stopped");

    chk_strap_stable: assert property (@(posedge clk) disable iff (srst)
        state_reg != ST_TOTAL |=> $stable(strap_reg))
        else $error("strap changed outside reset");

    chk_mult_select: assert property (@(posedge clk) disable iff (srst)
        strap_reg.pll_on && strap_reg.clk_mode |=> pll_mult == 9'h191)
        else $error("multiplier wrong");

    chk_narrow_lanes: assert property (@(posedge clk) disable iff (srst)
        !strap_reg.bus_16 |=> !upper_lane_en)
        else $error("word lane in byte mode");

endmodule : reset_and_mode_strap_control

/* tb/reset_source_model.sv */
`timescale 1ns/1ps
module reset_source_model
    import reset_strap_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic total_req, // Bench asks for a total reset
    input wire logic halt_req, // Bench asks for halt alone
    input wire logic reset_pin_out, // Device level on the reset pin
    input wire logic reset_pin_oe_n, // Device enable, low drives
    output logic reset_pin_n_in, // Resolved reset line
    output logic halt_pin_n_in // Resolved halt line
);
    logic [4:0] hold_reg;
    logic src_low;

    // Keep both pins low the least total reset length after a request
    always_ff @(posedge clk)
    begin
        if (srst)
            hold_reg <= 5'h0;
        else if (total_req)
            hold_reg <= 5'(TOTAL_MIN_CYCLES);
        else if (hold_reg != 5'h0)
            hold_reg <= hold_reg - 5'h1;
    end

    // Fast clock only; a slow crystal source must hold far longer
    // Open-drain lines with pull-ups: any party pulling low wins
    assign src_low = total_req | (hold_reg != 5'h0);
    assign reset_pin_n_in = ~src_low & (reset_pin_oe_n | reset_pin_out);
    assign halt_pin_n_in = ~(src_low | halt_req);
endmodule : reset_source_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import reset_strap_pkg::*;
    logic clk = 1'b0, srst = 1'b1, bw = 1'b0, cd = 1'b0, cm = 1'b0, pll = 1'b0;
    logic req_n = 1'b1, instr = 1'b0, done = 1'b0, ub_n = 1'b1, lb_n = 1'b1;
    logic total_req = 1'b0, halt_req = 1'b0, rst_n, halt_n, rst_out, rst_oe_n, grant_n;
    logic total_reset, core_reset, comms_reset, integ_reset, port_line, stopped;
    logic up_en, lo_en, ram_word, ck_en;
    logic [3:0] pbit = 4'h0, preset;
    logic [8:0] mult;
    drive_t cfg = DRIVE_FULL, ck_drive;
    pin_ctrl_t pins;
    strap_t straps;
    int errors = 0, cmp_count = 0;

    always #4 clk = ~clk;

    reset_and_mode_strap_control i_reset_and_mode_strap_control (.clk(clk), .srst(srst),
        .reset_pin_n_in(rst_n), .halt_pin_n_in(halt_n), .bus_width_select(bw),
        .core_disable_strap(cd), .clock_mode_strap(cm), .pll_supply_strap(pll),
        .request_input_n(req_n), .reset_instr(instr), .periph_reset_bit(pbit),
        .bus_cycle_done(done), .upper_byte_strobe_n(ub_n), .lower_byte_strobe_n(lb_n),
        .clk_drive_cfg(cfg), .reset_pin_out(rst_out), .reset_pin_oe_n(rst_oe_n),
        .grant_output_n(grant_n), .total_reset(total_reset), .core_reset(core_reset),
        .comms_reset(comms_reset), .integ_reset(integ_reset), .periph_reset(preset),
        .pin_ctrl(pins), .straps(straps), .pll_mult(mult), .port_a_line_twelve(port_line),
        .master_stopped(stopped), .upper_lane_en(up_en), .lower_lane_en(lo_en),
        .comms_ram_word(ram_word), .clkout_enable(ck_en), .clkout_drive(ck_drive));

    reset_source_model i_reset_source_model (.clk(clk), .srst(srst), .total_req(total_req),
        .halt_req(halt_req), .reset_pin_out(rst_out), .reset_pin_oe_n(rst_oe_n),
        .reset_pin_n_in(rst_n), .halt_pin_n_in(halt_n));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic final_report();
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic total_run(input logic b, c, p, m, input logic [8:0] exp_mult);
        int i;
        @(posedge clk);
        {bw, cd, pll, cm} <= {b, c, p, m};
        total_req <= 1'b1;
        for (i = 0; i < 10 && total_reset !== 1'b1; i++) step(1);
        check(9'(total_reset), 9'h1, "total reset start");
        check(9'(pins), 9'h03f, "pad states");
        check({6'h0, ck_en, ck_drive}, 9'h007, "clock out in reset");
        check({2'h0, core_reset, comms_reset, integ_reset, preset}, 9'h07f, "fan-out");
        @(posedge clk);
        req_n <= 1'b0;
        step(4);
        check(9'(grant_n), 9'h0, "grant low");
        @(posedge clk);
        req_n <= 1'b1;
        step(4);
        check(9'(grant_n), 9'h1, "grant high");
        @(posedge clk);
        total_req <= 1'b0;
        for (i = 0; i < 20 && total_reset !== 1'b0; i++) step(1);
        @(posedge clk);
        // Only the clock mode pin may move now; width and core straps stay put
        cm <= ~m;
        step(4);
        check(9'(straps), {5'h0, b, c, p, p & m}, "straps held");
        check(mult, exp_mult, "pll factor");
        check(9'(port_line), {8'h0, ~m}, "port line");
        check(9'(total_reset), 9'h0, "total reset end");
    endtask : total_run

    task automatic lanes(input logic wide);
        @(posedge clk);
        {ub_n, lb_n} <= 2'b01;
        step(2);
        check({7'h0, up_en, lo_en}, {7'h0, wide, ~wide}, "upper strobe");
        check(9'(ram_word), 9'h1, "comms word");
        @(posedge clk);
        {ub_n, lb_n} <= 2'b11;
    endtask : lanes

    task automatic soft_run();
        int i, n;
        @(posedge clk);
        instr <= 1'b1;
        @(posedge clk);
        instr <= 1'b0;
        for (i = 0; i < 4 && rst_oe_n !== 1'b0; i++) step(1);
        check({5'h0, rst_out, comms_reset, integ_reset, core_reset}, 9'h006, "soft");
        n = 0;
        while (rst_oe_n === 1'b0 && n < 200)
        begin
            @(posedge clk);
            instr <= (n == 60);
            #1;
            n++;
        end
        check(9'(n), 9'd124, "soft length");
        check(9'(total_reset), 9'h0, "no self trigger");
    endtask : soft_run

    task automatic periph_run();
        int k;
        for (k = 0; k < 4; k++)
        begin
            @(posedge clk);
            pbit <= 4'h1 << k;
            step(1);
            check(9'(preset), 9'(4'h1 << k), "peripheral reset");
            @(posedge clk);
            pbit <= 4'h0;
        end
    endtask : periph_run

    task automatic halt_run();
        @(posedge clk);
        halt_req <= 1'b1;
        step(5);
        check(9'(stopped), 9'h0, "stop before cycle end");
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        step(2);
        check({7'h0, stopped, total_reset}, 9'h002, "halt stop");
        step(2);
        check(9'(stopped), 9'h1, "stop held for outside master");
        @(posedge clk);
        halt_req <= 1'b0;
        step(5);
        check(9'(stopped), 9'h0, "halt release");
    endtask : halt_run

    task automatic drive_run();
        int d;
        for (d = 0; d < 4; d++)
        begin
            @(posedge clk);
            cfg <= drive_t'(d);
            step(2);
            check({6'h0, ck_en, ck_drive}, 9'((d != 0) * 4 + d), "clock drive");
        end
    endtask : drive_run

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        step(3);
        check({3'h0, rst_out, rst_oe_n, grant_n, ck_en, ck_drive}, 9'h03f, "idle");
        total_run(1'b1, 1'b0, 1'b1, 1'b0, MULT_LOW);
        lanes(1'b1);
        soft_run();
        periph_run();
        halt_run();
        drive_run();
        total_run(1'b0, 1'b1, 1'b1, 1'b1, MULT_HIGH);
        lanes(1'b0);
        total_run(1'b1, 1'b0, 1'b0, 1'b1, MULT_BYPASS);
        final_report();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule : tb_top
